// ---- core/pmm_map.vh ----
// Offsets, field positions, code limits and timing figures of the management map
`ifndef PMM_MAP_VH
`define PMM_MAP_VH
// Lower page
`define PMM_TYPE_ID_OFS 8'h00
`define PMM_STATUS_HI_OFS 8'h01
`define PMM_STATUS_LO_OFS 8'h02
`define PMM_LOCK_LOSS_OFS 8'h05
`define PMM_RO_LAST 8'h55
`define PMM_CTRL_FIRST 8'h56
`define PMM_CTRL_LAST 8'h61
`define PMM_RETIMER_EN_OFS 8'h62
`define PMM_MASK_FIRST 8'h64
`define PMM_MASK_LAST 8'h6A
`define PMM_LOCK_MASK_OFS 8'h64
`define PMM_PAGE_SEL_OFS 8'h7F
`define PMM_POWER_CTRL_OFS 8'h5D
`define PMM_POWER_OVR_BIT 1
`define PMM_NOT_READY_BIT 0
// Upper page 00
`define PMM_PAGE_ID 8'h00
`define PMM_PAGE_THRESH 8'h03
`define PMM_BITRATE_OFS 8'h8C
`define PMM_WAVE_HI_OFS 8'hBA
`define PMM_WAVE_LO_OFS 8'hBB
`define PMM_WTOL_HI_OFS 8'hBC
`define PMM_WTOL_LO_OFS 8'hBD
`define PMM_BASE_CK_OFS 8'hBF
`define PMM_EXT_CK_OFS 8'hDF
`define PMM_BASE_FIRST 8'h80
`define PMM_EXT_FIRST 8'hC0
// Upper page 03
`define PMM_THR_LAST 8'hAF
`define PMM_EQ_OFS 8'hEA
`define PMM_EMPH_OFS 8'hEC
`define PMM_AMPL_OFS 8'hEE
`define PMM_CHCTRL_FIRST 8'hF0
`define PMM_CHCTRL_LAST 8'hF1
`define PMM_EQ_MAX 4'hA
`define PMM_EMPH_MAX 4'h7
`define PMM_AMPL_MAX 4'h3
// Timing, figures as printed
`define PMM_CLK_MHZ 100
`define PMM_RESET_MIN_US 2
`define PMM_INIT_MS 2000
`define PMM_LOWPWR_US 100
`define PMM_SELECT_US 100
`define PMM_ATTN_RELEASE_US 500
`define PMM_RESET_MIN_CYC (`PMM_RESET_MIN_US * `PMM_CLK_MHZ)
`define PMM_INIT_CYC (`PMM_INIT_MS * 1000 * `PMM_CLK_MHZ)
`define PMM_SELECT_CYC (`PMM_SELECT_US * `PMM_CLK_MHZ)
`endif

// ---- core/pmm_sync.v ----
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module pmm_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire core_clk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  // First stage feeds only the second
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // pmm_sync

// ---- core/pmm_ram.v ----
// Small byte memory with registered read data for general control bytes
`timescale 1ns/1ps
module pmm_ram #(
  parameter AW = 5
) (
  input wire core_clk,
  input wire rst_n,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer i;
  // Cleared on reset so user settings return to defaults
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < (1<<AW); i = i + 1) begin
        mem[i] <= 8'h00;
      end
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule // pmm_ram

// ---- core/pmm_mgmt.v ----
// Management register space of the four-lane module behind a two-wire slave
`timescale 1ns/1ps
`include "pmm_map.vh"
module pmm_mgmt #(
  parameter [7:0] TYPE_ID = 8'h11,
  parameter [7:0] DEV_ADDR7 = 8'h50,
  parameter [7:0] BIT_RATE = 8'hFF,
  parameter [15:0] WAVE_X20 = 16'h0000,
  parameter [15:0] WTOL_X200 = 16'h0000,
  parameter integer INIT_CYC = `PMM_INIT_CYC
) (
  input wire core_clk,
  input wire rst_n,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  input wire device_select_n,
  input wire module_reset_n,
  input wire low_power_pin,
  output reg attention_n_out,
  output reg attention_n_oe_n,
  input wire [3:0] tx_lock_loss,
  input wire [3:0] rx_lock_loss,
  output reg [3:0] tx_retimer_on,
  output reg [3:0] rx_retimer_on,
  output reg [15:0] tx_eq_codes,
  output reg [15:0] rx_emph_codes,
  output reg [15:0] rx_ampl_codes,
  output reg low_power
);
  // Local reset released through two flops
  reg rst_m1, rst_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m1 <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m1 <= 1'b1;
      rst_q <= rst_m1;
    end
  end
  // Pins into this domain
  // Reset values match the idle pin levels, so no false edge or power blip
  wire [4:0] pins_s;
  wire [7:0] lol_s;
  pmm_sync #(.WIDTH(5), .INIT(5'h1E)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_q),
    .async_in({scl, sda_in, device_select_n, module_reset_n, low_power_pin}),
    .sync_out(pins_s)
  );
  pmm_sync #(.WIDTH(8), .INIT(8'h00)) u_lol_sync (
    .core_clk(core_clk),
    .rst_n(rst_q),
    .async_in({tx_lock_loss, rx_lock_loss}),
    .sync_out(lol_s)
  );
  wire scl_s = pins_s[4];
  wire sda_s = pins_s[3];
  wire sel_n_s = pins_s[2];
  wire mreset_s = pins_s[1];
  wire lp_s = pins_s[0];
  // Reset pin filter: low longer than minimum pulse makes a soft reset
  reg [8:0] rst_cnt;
  reg soft_rst;
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      rst_cnt <= 9'h000;
      soft_rst <= 1'b0;
    end else if (mreset_s) begin
      rst_cnt <= 9'h000;
      soft_rst <= 1'b0;
    end else if (rst_cnt != `PMM_RESET_MIN_CYC) begin
      rst_cnt <= rst_cnt + 9'h001;
    end else begin
      soft_rst <= 1'b1;
    end
  end
  // Init timer from power on or reset release
  reg [31:0] init_cnt;
  reg ready;
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      init_cnt <= 32'h00000000;
      ready <= 1'b0;
    end else if (soft_rst) begin
      init_cnt <= 32'h00000000;
      ready <= 1'b0;
    end else if (init_cnt >= INIT_CYC[31:0] - 32'h00000001) begin
      ready <= 1'b1;
    end else begin
      init_cnt <= init_cnt + 32'h00000001;
    end
  end
  // Select pin qualification, held low for four cycles before answering
  reg [13:0] sel_cnt;
  reg sel_ok;
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      sel_cnt <= 14'h0000;
      sel_ok <= 1'b0;
    end else if (sel_n_s) begin
      sel_cnt <= 14'h0000;
      sel_ok <= 1'b0;
    end else if (sel_cnt != 14'h0003) begin
      sel_cnt <= sel_cnt + 14'h0001;
    end else begin
      sel_ok <= 1'b1;
    end
  end
  // Bus edge and start/stop detection on synchronised lines
  reg scl_d, sda_d;
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_c = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
  // Serial slave states
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_RACK = 3'd5;
  reg [2:0] st;
  reg [3:0] bitn;
  reg [7:0] shreg;
  reg rd_mode, have_ptr, ack_go;
  reg [7:0] ptr;
  reg [7:0] page_sel;
  reg [7:0] lock_flags, lock_mask, retimer_en, power_ctrl;
  reg [7:0] thr_ctrl [0:1];
  reg wr_pulse, rd_pulse;
  reg [7:0] wr_byte;
  wire busy_ok = ready & sel_ok & ~soft_rst;
  // Control bytes other than the dedicated ones live in the small memory
  wire [7:0] ram_q;
  wire ram_we = wr_pulse & (ptr >= `PMM_CTRL_FIRST) & (ptr <= `PMM_MASK_LAST) &
    (ptr != `PMM_RETIMER_EN_OFS) & (ptr != 8'h63) & (ptr != `PMM_LOCK_MASK_OFS) &
    (ptr != `PMM_POWER_CTRL_OFS);
  pmm_ram #(.AW(5)) u_ctrl_ram (
    .core_clk(core_clk),
    .rst_n(rst_q & ~soft_rst),
    .wr_en(ram_we),
    .wr_addr(ptr[4:0] - 5'h16),
    .wr_data(wr_byte),
    .rd_addr(ptr[4:0] - 5'h16),
    .rd_data(ram_q)
  );
  // Upper page 00 ID contents; checksums are sums of the byte ranges
  function [7:0] id_byte;
    input [7:0] a;
    begin
      case (a)
        8'h80: id_byte = TYPE_ID;
        `PMM_BITRATE_OFS: id_byte = BIT_RATE;
        `PMM_WAVE_HI_OFS: id_byte = WAVE_X20[15:8];
        `PMM_WAVE_LO_OFS: id_byte = WAVE_X20[7:0];
        `PMM_WTOL_HI_OFS: id_byte = WTOL_X200[15:8];
        `PMM_WTOL_LO_OFS: id_byte = WTOL_X200[7:0];
        default: id_byte = 8'h00;
      endcase
    end
  endfunction
  wire [7:0] base_ck = TYPE_ID + BIT_RATE + WAVE_X20[15:8] + WAVE_X20[7:0] +
    WTOL_X200[15:8] + WTOL_X200[7:0];
  wire [7:0] ext_ck = 8'h00;
  // Read mux for the byte at the pointer
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (ptr == `PMM_TYPE_ID_OFS) begin
      rd_byte = TYPE_ID;
    end else if (ptr == `PMM_STATUS_LO_OFS) begin
      rd_byte = {7'h00, ~ready};
    end else if (ptr == `PMM_LOCK_LOSS_OFS) begin
      rd_byte = lock_flags;
    end else if (ptr == `PMM_RETIMER_EN_OFS) begin
      rd_byte = retimer_en;
    end else if (ptr == `PMM_LOCK_MASK_OFS) begin
      rd_byte = lock_mask;
    end else if (ptr == `PMM_POWER_CTRL_OFS) begin
      rd_byte = power_ctrl;
    end else if (ptr == `PMM_PAGE_SEL_OFS) begin
      rd_byte = page_sel;
    end else if (ptr >= `PMM_CTRL_FIRST && ptr <= `PMM_MASK_LAST) begin
      rd_byte = ram_q;
    end else if (ptr[7] && page_sel == `PMM_PAGE_ID) begin
      if (ptr == `PMM_BASE_CK_OFS) begin
        rd_byte = base_ck;
      end else if (ptr == `PMM_EXT_CK_OFS) begin
        rd_byte = ext_ck;
      end else begin
        rd_byte = id_byte(ptr);
      end
    end else if (ptr[7] && page_sel == `PMM_PAGE_THRESH) begin
      if (ptr >= `PMM_EQ_OFS && ptr <= `PMM_CHCTRL_LAST) begin
        rd_byte = thr_ctrl_rd(ptr);
      end else begin
        rd_byte = 8'h00;
      end
    end
  end
  function [7:0] thr_ctrl_rd;
    input [7:0] a;
    begin
      case (a)
        8'hEA: thr_ctrl_rd = tx_eq_codes[15:8];
        8'hEB: thr_ctrl_rd = tx_eq_codes[7:0];
        8'hEC: thr_ctrl_rd = rx_emph_codes[15:8];
        8'hED: thr_ctrl_rd = rx_emph_codes[7:0];
        8'hEE: thr_ctrl_rd = rx_ampl_codes[15:8];
        8'hEF: thr_ctrl_rd = rx_ampl_codes[7:0];
        8'hF0: thr_ctrl_rd = thr_ctrl[0];
        8'hF1: thr_ctrl_rd = thr_ctrl[1];
        default: thr_ctrl_rd = 8'h00;
      endcase
    end
  endfunction
  // Two-wire slave state machine; ACK and data driven after SCL falls
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      st <= ST_IDLE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      rd_mode <= 1'b0;
      have_ptr <= 1'b0;
      ack_go <= 1'b0;
      ptr <= 8'h00;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      wr_byte <= 8'h00;
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (!busy_ok || stop_c) begin
        st <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_c) begin
        st <= ST_ADDR;
        bitn <= 4'h0;
        sda_oe_n <= 1'b1;
      end else begin
        case (st)
          ST_ADDR, ST_WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'h1;
            end else if (scl_fall && bitn == 4'h8) begin
              bitn <= 4'h0;
              if (st == ST_ADDR) begin
                ack_go <= (shreg[7:1] == DEV_ADDR7[6:0]);
                rd_mode <= shreg[0];
                have_ptr <= 1'b0;
              end else begin
                ack_go <= 1'b1;
                if (!have_ptr) begin
                  ptr <= shreg;
                  have_ptr <= 1'b1;
                end else begin
                  wr_byte <= shreg;
                  wr_pulse <= 1'b1;
                end
              end
              sda_oe_n <= ~((st == ST_WDATA) | (shreg[7:1] == DEV_ADDR7[6:0]));
              sda_out <= 1'b0;
              st <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_go) begin
                st <= ST_IDLE;
                sda_oe_n <= 1'b1;
              end else if (rd_mode) begin
                shreg <= rd_byte;
                sda_out <= rd_byte[7];
                sda_oe_n <= rd_byte[7];
                rd_pulse <= 1'b1;
                bitn <= 4'h1;
                st <= ST_RDATA;
              end else begin
                sda_oe_n <= 1'b1;
                st <= ST_WDATA;
              end
            end
          end
          ST_RDATA: begin
            if (scl_fall) begin
              if (bitn == 4'h8) begin
                sda_oe_n <= 1'b1;
                ptr <= ptr + 8'h01;
                st <= ST_RACK;
              end else begin
                sda_out <= shreg[7-bitn];
                sda_oe_n <= shreg[7-bitn];
                bitn <= bitn + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ack_go <= ~sda_s;
              st <= sda_s ? ST_IDLE : ST_ACK;
            end
          end
          default: st <= ST_IDLE;
        endcase
      end
    end
  end
  // Writable registers and latched flags
  wire upper3 = ptr[7] & (page_sel == `PMM_PAGE_THRESH);
  // Clear only the bits that went out, so a later event survives the read
  wire [7:0] flag_clr = (rd_pulse && ptr == `PMM_LOCK_LOSS_OFS) ? shreg : 8'h00;
  // Lower address byte carries the higher channels in its upper nibble
  wire [3:0] hi_nib = {~ptr[0], 3'b111};
  wire [3:0] lo_nib = {~ptr[0], 3'b011};
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      lock_flags <= 8'h00;
      lock_mask <= 8'h00;
      retimer_en <= 8'h00;
      power_ctrl <= 8'h00;
      page_sel <= 8'h00;
      thr_ctrl[0] <= 8'h00;
      thr_ctrl[1] <= 8'h00;
      tx_eq_codes <= 16'h0000;
      rx_emph_codes <= 16'h0000;
      rx_ampl_codes <= 16'h0000;
    end else if (soft_rst) begin
      lock_flags <= 8'h00;
      lock_mask <= 8'h00;
      retimer_en <= 8'h00;
      power_ctrl <= 8'h00;
      page_sel <= 8'h00;
      thr_ctrl[0] <= 8'h00;
      thr_ctrl[1] <= 8'h00;
      tx_eq_codes <= 16'h0000;
      rx_emph_codes <= 16'h0000;
      rx_ampl_codes <= 16'h0000;
    end else begin
      // Set beats clear on read so no event is lost
      lock_flags <= (lock_flags & ~flag_clr) | lol_s;
      if (wr_pulse) begin
        if (ptr == `PMM_RETIMER_EN_OFS) retimer_en <= wr_byte;
        if (ptr == `PMM_LOCK_MASK_OFS) lock_mask <= wr_byte;
        if (ptr == `PMM_POWER_CTRL_OFS) power_ctrl <= wr_byte;
        if (ptr == `PMM_PAGE_SEL_OFS) page_sel <= wr_byte;
        if (upper3 && ptr == 8'hF0) thr_ctrl[0] <= wr_byte;
        if (upper3 && ptr == 8'hF1) thr_ctrl[1] <= wr_byte;
        // Reserved codes refused, previous nibble kept
        if (upper3 && ptr[7:1] == 7'h75) begin
          if (wr_byte[7:4] <= `PMM_EQ_MAX) tx_eq_codes[hi_nib -: 4] <= wr_byte[7:4];
          if (wr_byte[3:0] <= `PMM_EQ_MAX) tx_eq_codes[lo_nib -: 4] <= wr_byte[3:0];
        end
        if (upper3 && ptr[7:1] == 7'h76) begin
          if (!wr_byte[7]) rx_emph_codes[hi_nib -: 4] <= wr_byte[7:4];
          if (!wr_byte[3]) rx_emph_codes[lo_nib -: 4] <= wr_byte[3:0];
        end
        if (upper3 && ptr[7:1] == 7'h77) begin
          if (wr_byte[7:4] <= `PMM_AMPL_MAX) rx_ampl_codes[hi_nib -: 4] <= wr_byte[7:4];
          if (wr_byte[3:0] <= `PMM_AMPL_MAX) rx_ampl_codes[lo_nib -: 4] <= wr_byte[3:0];
        end
      end
    end
  end
  // Attention, retimer and power outputs; ready posts attention until status is read
  reg ready_seen;
  always @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      attention_n_out <= 1'b0;
      attention_n_oe_n <= 1'b1;
      ready_seen <= 1'b0;
      tx_retimer_on <= 4'h0;
      rx_retimer_on <= 4'h0;
      low_power <= 1'b0;
    end else begin
      if (soft_rst) begin
        ready_seen <= 1'b0;
      end else if (ready && rd_pulse && ptr == `PMM_STATUS_LO_OFS) begin
        ready_seen <= 1'b1;
      end
      attention_n_out <= 1'b0;
      attention_n_oe_n <= ~(|(lock_flags & ~lock_mask) |
        (ready & ~ready_seen & ~soft_rst));
      tx_retimer_on <= retimer_en[7:4];
      rx_retimer_on <= retimer_en[3:0];
      low_power <= lp_s | power_ctrl[`PMM_POWER_OVR_BIT];
    end
  end
endmodule // pmm_mgmt

// ---- tb/pmm_mgmt_monitor.sv ----
// Port-level checks of the management block
`timescale 1ns/1ps
module pmm_mgmt_chk #(
  parameter integer INIT_CYC = 50
) (
  input wire core_clk,
  input wire rst_n,
  input wire scl,
  input wire sda_oe_n,
  input wire device_select_n,
  input wire module_reset_n,
  input wire low_power_pin,
  input wire attention_n_out,
  input wire attention_n_oe_n,
  input wire [3:0] tx_retimer_on,
  input wire [3:0] rx_retimer_on,
  input wire [15:0] tx_eq_codes,
  input wire [15:0] rx_emph_codes,
  input wire [15:0] rx_ampl_codes,
  input wire low_power
);
  localparam int READY_WAIT = INIT_CYC + 60;
  int low_cnt;
  int bus_idle;
  logic scl_q;
  // Low spell on the reset pin, and quiet time since bus or reset activity
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      bus_idle <= 0;
      scl_q <= 1'b1;
    end else begin
      scl_q <= scl;
      low_cnt <= module_reset_n ? 0 : (low_cnt < 1000 ? low_cnt + 1 : low_cnt);
      bus_idle <= (scl != scl_q || !module_reset_n) ? 0 : (bus_idle < 60000 ? bus_idle + 1 : bus_idle);
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Long pulse on the reset pin, then its release
  sequence s_long_reset_end;
    (low_cnt > 210) ##1 module_reset_n;
  endsequence
  a_ready_after_reset: assert property (s_long_reset_end |-> ##[1:READY_WAIT] !attention_n_oe_n)
    else $error("attention not posted after module reset");
  a_quiet_soft_reset: assert property ((low_cnt > 210) |-> sda_oe_n)
    else $error("data driven during module reset");
  a_soft_defaults: assert property ((low_cnt == 220) |->
    {tx_retimer_on, rx_retimer_on, tx_eq_codes, rx_emph_codes, rx_ampl_codes} == 56'h0)
    else $error("settings not back to defaults");
  a_quiet_unselected: assert property (device_select_n [*8] |=> sda_oe_n)
    else $error("data driven while not selected");
  a_lowpwr_pin: assert property (low_power_pin [*6] |=> low_power)
    else $error("low power not entered");
  a_attn_open_drain: assert property (attention_n_out == 1'b0)
    else $error("attention pin drives high");
  a_eq_code_legal: assert property (tx_eq_codes[15:12] <= 4'hA && tx_eq_codes[11:8] <= 4'hA
    && tx_eq_codes[7:4] <= 4'hA && tx_eq_codes[3:0] <= 4'hA)
    else $error("reserved equalization code applied");
  a_emph_code_legal: assert property ((rx_emph_codes & 16'h8888) == 16'h0000)
    else $error("reserved emphasis code applied");
  a_ampl_code_legal: assert property ((rx_ampl_codes & 16'hCCCC) == 16'h0000)
    else $error("reserved amplitude code applied");
  a_attn_release_cause: assert property ($rose(attention_n_oe_n) |-> bus_idle < 50000)
    else $error("attention released without a read");
endmodule // pmm_mgmt_chk
bind pmm_mgmt pmm_mgmt_chk #(.INIT_CYC(INIT_CYC)) pmm_mgmt_chk_inst (
  .core_clk(core_clk), .rst_n(rst_n), .scl(scl), .sda_oe_n(sda_oe_n),
  .device_select_n(device_select_n), .module_reset_n(module_reset_n),
  .low_power_pin(low_power_pin), .attention_n_out(attention_n_out),
  .attention_n_oe_n(attention_n_oe_n), .tx_retimer_on(tx_retimer_on),
  .rx_retimer_on(rx_retimer_on), .tx_eq_codes(tx_eq_codes), .rx_emph_codes(rx_emph_codes),
  .rx_ampl_codes(rx_ampl_codes), .low_power(low_power));

// ---- tb/pmm_host.sv ----
// Host controller model: two-wire master with open-drain data
`timescale 1ns/1ps
module pmm_host #(
  parameter [6:0] ADDR7 = 7'h50
) (
  output logic scl,
  output logic sda_rel,
  input logic sda_line
);
  localparam realtime Q = 31.25;
  // Clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic put(input logic b);
    sda_rel = b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  task automatic get(output logic b);
    sda_rel = 1'b1;
    #Q scl = 1'b1;
    #Q b = sda_line;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Long low phase first, so a late acknowledge cannot fake a stop
  task automatic frame_begin();
    sda_rel = 1'b1;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_rel = 1'b0;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask
  task automatic frame_end();
    sda_rel = 1'b0;
    #(2*Q) scl = 1'b1;
    #(2*Q) sda_rel = 1'b1;
    #(2*Q);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(n);
    ack = ~n;
  endtask
  // Pointer write then data: one byte per frame
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    frame_begin();
    send({ADDR7, 1'b0}, a0);
    send(p, a1);
    send(d, a2);
    frame_end();
    ok = a0 & a1 & a2;
  endtask
  // Pointer write, repeated start, one byte read and not acknowledged
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    frame_begin();
    send({ADDR7, 1'b0}, a0);
    send(p, a1);
    frame_begin();
    send({ADDR7, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(1'b1);
    frame_end();
    ok = a0 & a1 & a2;
  endtask
endmodule // pmm_host

// ---- tb/pmm_mgmt_tb.sv ----
// Self-checking bench for the management block
`timescale 1ns/1ps
module pmm_mgmt_tb;
  localparam [7:0] TID = 8'h11;
  localparam [7:0] BR = 8'hFA;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic device_select_n = 1'b0;
  logic module_reset_n = 1'b1;
  logic low_power_pin = 1'b0;
  logic [3:0] tx_lock_loss = 4'h0;
  logic [3:0] rx_lock_loss = 4'h0;
  logic scl, sda_rel, sda_out, sda_oe_n, attention_n_out, attention_n_oe_n, low_power, ok;
  logic [3:0] tx_retimer_on, rx_retimer_on;
  logic [15:0] tx_eq_codes, rx_emph_codes, rx_ampl_codes;
  logic [31:0] rows [14];
  logic [7:0] d, sum;
  int fails = 0;
  int comparisons = 0;
  wire sda_line = sda_rel & (sda_oe_n | sda_out);
  always #5 core_clk = ~core_clk;
  pmm_mgmt #(.TYPE_ID(TID), .BIT_RATE(BR), .WAVE_X20(16'h6540), .WTOL_X200(16'h00C8),
    .INIT_CYC(50)) pmm_mgmt_inst (.core_clk(core_clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .device_select_n(device_select_n), .module_reset_n(module_reset_n),
    .low_power_pin(low_power_pin), .attention_n_out(attention_n_out),
    .attention_n_oe_n(attention_n_oe_n), .tx_lock_loss(tx_lock_loss),
    .rx_lock_loss(rx_lock_loss), .tx_retimer_on(tx_retimer_on), .rx_retimer_on(rx_retimer_on),
    .tx_eq_codes(tx_eq_codes), .rx_emph_codes(rx_emph_codes), .rx_ampl_codes(rx_ampl_codes),
    .low_power(low_power));
  pmm_host pmm_host_inst (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_attn(input logic lvl, input int lim);
    int n;
    n = 0;
    while (attention_n_oe_n !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    chk(attention_n_oe_n, lvl);
  endtask
  task automatic wrp(input logic [7:0] p, input logic [7:0] v);
    tick(1);
    pmm_host_inst.wr(p, v, ok);
  endtask
  task automatic rdp(input logic [7:0] p, output logic [7:0] v);
    tick(1);
    pmm_host_inst.rd(p, v, ok);
  endtask
  task wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Hang guard, past the expected run of some 73k cycles
  initial begin
    repeat (95000) @(posedge core_clk);
    fails++;
    wrap_up();
  end
  // Page, pointer, data written, byte read back
  initial begin
    rows[0] = {8'h00, 8'h00, 8'h5A, TID};
    rows[1] = 32'h0062A5A5;
    rows[2] = {8'h00, 8'h8C, BR, BR};
    rows[3] = 32'h00BA6565;
    rows[4] = 32'h00BB4040;
    rows[5] = 32'h00BC0000;
    rows[6] = 32'h00BDC8C8;
    rows[7] = 32'h03EA5A5A;
    rows[8] = 32'h03EABB5A;
    rows[9] = 32'h03EC7070;
    rows[10] = 32'h03EC8870;
    rows[11] = 32'h03EE3131;
    rows[12] = 32'h03EE4431;
    rows[13] = 32'h03F03C3C;
  end
  // Main sequence
  initial begin
    tick(16);
    rst_n = 1'b1;
    tick(2);
    chk({tx_retimer_on, rx_retimer_on, tx_eq_codes}, 24'h0);
    wait_attn(1'b0, 200);
    rdp(8'h02, d);
    chk(d[0], 1'b0);
    wait_attn(1'b1, 50000);
    foreach (rows[i]) begin
      if (rows[i][23:16] >= 8'h80) wrp(8'h7F, rows[i][31:24]);
      wrp(rows[i][23:16], rows[i][15:8]);
      rdp(rows[i][23:16], d);
      chk(d, rows[i][7:0]);
    end
    chk({tx_retimer_on, rx_retimer_on}, 8'hA5);
    chk({tx_eq_codes[15:8], rx_emph_codes[15:8], rx_ampl_codes[15:8]}, 24'h5A7031);
    // Check codes summed over the identity bytes
    wrp(8'h7F, 8'h00);
    sum = 8'h00;
    for (int a = 128; a < 191; a++) begin
      rdp(8'(a), d);
      sum += d;
    end
    rdp(8'hBF, d);
    chk(d, sum);
    sum = 8'h00;
    for (int a = 192; a < 223; a++) begin
      rdp(8'(a), d);
      sum += d;
    end
    rdp(8'hDF, d);
    chk(d, sum);
    // Lock loss latches, raises attention, clears on read
    tx_lock_loss = 4'b0010;
    tick(8);
    tx_lock_loss = 4'h0;
    wait_attn(1'b0, 1000);
    rdp(8'h05, d);
    chk(d, 8'h20);
    wait_attn(1'b1, 50000);
    rdp(8'h05, d);
    chk(d, 8'h00);
    // Masked flag stays quiet until unmasked
    wrp(8'h64, 8'hFF);
    rx_lock_loss = 4'b0001;
    tick(8);
    rx_lock_loss = 4'h0;
    tick(100);
    chk(attention_n_oe_n, 1'b1);
    wrp(8'h64, 8'h00);
    wait_attn(1'b0, 1000);
    rdp(8'h05, d);
    chk(d, 8'h01);
    wait_attn(1'b1, 50000);
    // Low power by pin and by override bit
    low_power_pin = 1'b1;
    tick(10);
    chk(low_power, 1'b1);
    low_power_pin = 1'b0;
    tick(10);
    chk(low_power, 1'b0);
    wrp(8'h5D, 8'h02);
    tick(10);
    chk(low_power, 1'b1);
    wrp(8'h5D, 8'h00);
    tick(10);
    chk(low_power, 1'b0);
    // Deselected module ignores the bus; released line reads high
    device_select_n = 1'b1;
    tick(20);
    rdp(8'h62, d);
    chk({ok, d}, 9'h0FF);
    device_select_n = 1'b0;
    tick(20);
    rdp(8'h62, d);
    chk({ok, d}, 9'h1A5);
    // Long pulse on the reset pin restores defaults
    module_reset_n = 1'b0;
    tick(250);
    module_reset_n = 1'b1;
    wait_attn(1'b0, 200);
    rdp(8'h62, d);
    chk({d, tx_retimer_on, tx_eq_codes}, 28'h0);
    rdp(8'h02, d);
    chk(d[0], 1'b0);
    wrap_up();
  end
endmodule // pmm_mgmt_tb
